// ===== core/pbk_pkg.sv
// package: widths, codes, offsets, defaults and types of the parameter set bank
package pbk_pkg;
  localparam int NBANK = 8;
  localparam int BW = 3;
  localparam int VW = 16;
  // register word offsets, per-bank fields at BANK_BASE + bank*BANK_STRIDE + field*4
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SELECT = 8'h04;
  localparam logic [7:0] OFF_ACTIVE = 8'h08;
  localparam logic [7:0] OFF_MV_IN = 8'h0C;
  localparam logic [7:0] OFF_MV_OUT = 8'h10;
  localparam logic [7:0] OFF_TUNE_P = 8'h14;
  localparam logic [7:0] OFF_TUNE_I = 8'h18;
  localparam logic [7:0] OFF_TUNE_D = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_VIEW_DATA = 8'h24;
  localparam logic [7:0] OFF_VIEW_FIELD = 8'h28;
  localparam logic [3:0] NFIELD = 4'hC;
  // field indexes inside one bank
  localparam logic [3:0] F_P = 4'h0;
  localparam logic [3:0] F_I = 4'h1;
  localparam logic [3:0] F_D = 4'h2;
  localparam logic [3:0] F_CP = 4'h3;
  localparam logic [3:0] F_CI = 4'h4;
  localparam logic [3:0] F_CD = 4'h5;
  localparam logic [3:0] F_DB = 4'h6;
  localparam logic [3:0] F_MR = 4'h7;
  localparam logic [3:0] F_OLH = 4'h8;
  localparam logic [3:0] F_OLL = 4'h9;
  localparam logic [3:0] F_ASEL = 4'hA;
  localparam logic [3:0] F_LBA = 4'hB;
  // control bit positions
  localparam int C_TUNIT = 0;
  localparam int C_ANALOG = 1;
  localparam int C_HEATCOOL = 2;
  localparam int C_FLOAT = 3;
  localparam int C_TUNE = 4;
  localparam int C_STEP_UP = 5;
  localparam int C_STEP_DN = 6;
  localparam int C_MON_ON = 7;
  // status bit positions
  localparam int S_MON = 0;
  localparam int S_TUNE_DONE = 1;
  localparam int S_CLAMP_HI = 2;
  localparam int S_CLAMP_LO = 3;
  // defaults in tenths (time unit 1 s: whole values)
  localparam logic [VW-1:0] DEF_P_TEMP = 16'h0050;
  localparam logic [VW-1:0] DEF_P_ANA = 16'h0064;
  localparam logic [VW-1:0] DEF_I_S = 16'h00E9;
  localparam logic [VW-1:0] DEF_I_DS = 16'h091A;
  localparam logic [VW-1:0] DEF_D_S = 16'h0028;
  localparam logic [VW-1:0] DEF_D_DS = 16'h0190;
  localparam logic [VW-1:0] DEF_ZERO = 16'h0000;
  localparam logic [VW-1:0] DEF_MR = 16'h01F4;
  localparam logic [VW-1:0] DEF_OLH = 16'h03E8;
  localparam logic [VW-1:0] DEF_OLL_HC = 16'hFC18;
  localparam logic [VW-1:0] DEF_ASEL = 16'h0528;
  // accepted ranges, signed tenths (or hundredths for analog dead band)
  localparam logic [VW-1:0] P_MIN = 16'h0001;
  localparam logic [VW-1:0] T_MAX = 16'h270F;
  localparam logic [VW-1:0] DB_MIN_T = 16'hF831;
  localparam logic [VW-1:0] DB_MAX_T = 16'h270F;
  localparam logic [VW-1:0] DB_MIN_A = 16'hF831;
  localparam logic [VW-1:0] DB_MAX_A = 16'h270F;
  localparam logic [VW-1:0] MR_MAX = 16'h03E8;
  localparam logic [VW-1:0] OL_MAX = 16'h041A;
  localparam logic [VW-1:0] OL_MIN_STD = 16'hFFCE;
  localparam logic [VW-1:0] OL_MIN_HC = 16'hFBE6;
  localparam logic [VW-1:0] ONE_STEP = 16'h0001;
  localparam logic [BW-1:0] BANK_LAST = 3'h7;
  typedef logic [VW-1:0] pbk_val_t;
  // one bank of parameters
  typedef struct packed {
    pbk_val_t lba;
    pbk_val_t asel;
    pbk_val_t oll;
    pbk_val_t olh;
    pbk_val_t mr;
    pbk_val_t db;
    pbk_val_t cd;
    pbk_val_t ci;
    pbk_val_t cp;
    pbk_val_t d;
    pbk_val_t i;
    pbk_val_t p;
  } pbk_bank_t;
  // the limits and offsets the output stage needs from the active bank
  typedef struct packed {
    pbk_val_t upper;
    pbk_val_t lower;
    pbk_val_t dead_band;
    pbk_val_t bias;
    logic bias_en;
  } pbk_limits_t;
endpackage

// ===== core/pbk_field_clamp.sv
`timescale 1ns/1ps
// signed range check: folds a written value into [lo, hi]
module pbk_field_clamp (
  // value and bounds
  input wire logic [15:0] val,
  input wire logic [15:0] lo,
  input wire logic [15:0] hi,
  // folded result
  output logic [15:0] res
);
  // out-of-range writes land on the nearest bound, never rejected
  always_comb begin
    if ($signed(val) < $signed(lo)) begin
      res = lo;
    end else if ($signed(val) > $signed(hi)) begin
      res = hi;
    end else begin
      res = val;
    end
  end
endmodule

// ===== core/pbk_mv_stage.sv
`timescale 1ns/1ps
// output stage: dead band, offset bias and limits applied to the computed value
module pbk_mv_stage (
  // computed value, signed tenths of a percent, plus mode
  input wire logic [15:0] mv_in,
  input wire logic heat_cool,
  input wire logic floating,
  input wire logic derivative_add,
  input wire logic [15:0] derivative,
  // active bank values
  input wire pbk_pkg::pbk_limits_t lim,
  // result
  output logic [15:0] mv_out,
  output logic hit_hi,
  output logic hit_lo
);
  logic signed [17:0] sum;
  logic signed [17:0] db_half;
  // combine bias and derivative, then dead band, then limits
  always_comb begin
    sum = 18'($signed(mv_in));
    if (derivative_add) begin
      sum = sum + 18'($signed(derivative));
    end
    if (lim.bias_en) begin
      sum = sum + 18'($signed(lim.bias));
    end
    db_half = 18'($signed(lim.dead_band)) >>> 1;
    // negative dead band means overlap: no zone is forced
    if (heat_cool && !db_half[17] && sum <= db_half && sum >= -db_half) begin
      sum = '0;
    end
    hit_hi = 1'b0;
    hit_lo = 1'b0;
    // floating position control bypasses the limits entirely
    if (!floating && sum > 18'($signed(lim.upper))) begin
      sum = 18'($signed(lim.upper));
      hit_hi = 1'b1;
    end else if (!floating && sum < 18'($signed(lim.lower))) begin
      sum = 18'($signed(lim.lower));
      hit_lo = 1'b1;
    end
    if (sum > 18'sh07FFF) begin
      sum = 18'sh07FFF;
    end else if (sum < -18'sh08000) begin
      sum = -18'sh08000;
    end
    mv_out = sum[15:0];
  end
endmodule

// ===== core/pbk_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - eight independent banks hold constants, limits, dead band, bias, selection, break time
// - view selector 0..7, starts at active bank; stepping cancels monitoring
// - tuning run overwrites chosen bank's P, I, D with tuned values
// - time-unit bit picks seconds or tenths; defaults 233 and 40
// - changing time unit resets P, I, D, heating and cooling, every bank
// - proportional band 0.1..999.9; default 8.0 temperature, 10.0 analog
// - cooling constants per bank, tuned alongside heating in heat/cool mode
// - heat/cool dead band forces output zero around set point
// - negative dead band gives overlap; range by input type, default zero
// - integral zero adds bank bias 0..100.0, default 50.0
// - output beyond bank limits is replaced by the limit
// - floating position control ignores output limits
// - upper limit lower+0.1..105.0, default 100.0; heat/cool 0.0..105.0
// - lower limit -5.0..upper-0.1, default 0.0; heat/cool -105.0..0.0, default also 0.0
// - cooling output expressed negative, bounded by lower limit
// - derivative term adds in proportion to input rate of change
module pbk_bank (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // control path
  input wire logic [15:0] DERIV_TERM,
  output logic [15:0] MANIPULATED_VARIABLE
);
  localparam logic [7:0] BANK_BASE = 8'h40;
  localparam logic [7:0] BANK_STRIDE = 8'h30;
  localparam int BANK_SPAN = 384;
  // banks past the 8-bit map are edited through the view data word

  typedef struct packed {
    pbk_pkg::pbk_bank_t [pbk_pkg::NBANK-1:0] bank;
    logic [7:0] ctrl;
    logic [2:0] bank_view_select;
    logic [2:0] active;
    logic [3:0] view_field;
    logic monitor;
    logic tune_done;
    logic [15:0] mv_in;
    logic [15:0] tune_p;
    logic [15:0] tune_i;
    logic [15:0] tune_d;
    logic [15:0] mv_q;
    logic hi_q;
    logic lo_q;
    logic ack;
    logic [31:0] rdata;
  } pbk_state_t;

  pbk_state_t r;
  pbk_state_t next_r;
  // decoded request
  logic req;
  logic wr;
  // field target, by address or through the view selector
  logic [8:0] boff;
  logic via_view;
  logic [2:0] widx;
  logic [3:0] wfld;
  logic in_bank;
  // merged write value, old contents and accepted range
  logic [15:0] old_val;
  logic [15:0] wval;
  logic [15:0] lo_b;
  logic [15:0] hi_b;
  logic [15:0] clamped;
  // output stage and the active bank feeding it
  logic [15:0] mv_c;
  logic hit_hi;
  logic hit_lo;
  pbk_pkg::pbk_limits_t lim;
  pbk_pkg::pbk_bank_t act;
  // constants a time-unit change restores
  pbk_pkg::pbk_bank_t unit_dflt;

  // default bank content for the present input type and time unit
  function automatic pbk_pkg::pbk_bank_t bank_default(input logic analog,
                                                      input logic tenths,
                                                      input logic hc);
    pbk_pkg::pbk_bank_t b;
    b.p = analog ? pbk_pkg::DEF_P_ANA : pbk_pkg::DEF_P_TEMP;
    b.cp = b.p;
    b.i = tenths ? pbk_pkg::DEF_I_DS : pbk_pkg::DEF_I_S;
    b.ci = b.i;
    b.d = tenths ? pbk_pkg::DEF_D_DS : pbk_pkg::DEF_D_S;
    b.cd = b.d;
    b.db = pbk_pkg::DEF_ZERO;
    b.mr = pbk_pkg::DEF_MR;
    b.olh = pbk_pkg::DEF_OLH;
    b.oll = hc ? pbk_pkg::DEF_OLL_HC : pbk_pkg::DEF_ZERO;
    b.asel = pbk_pkg::DEF_ASEL;
    b.lba = pbk_pkg::DEF_ZERO;
    return b;
  endfunction

  // read one field of a bank by index
  function automatic logic [15:0] field_of(input pbk_pkg::pbk_bank_t b, input logic [3:0] f);
    logic [15:0] v;
    v = '0;
    unique case (f)
      pbk_pkg::F_P: v = b.p;
      pbk_pkg::F_I: v = b.i;
      pbk_pkg::F_D: v = b.d;
      pbk_pkg::F_CP: v = b.cp;
      pbk_pkg::F_CI: v = b.ci;
      pbk_pkg::F_CD: v = b.cd;
      pbk_pkg::F_DB: v = b.db;
      pbk_pkg::F_MR: v = b.mr;
      pbk_pkg::F_OLH: v = b.olh;
      pbk_pkg::F_OLL: v = b.oll;
      pbk_pkg::F_ASEL: v = b.asel;
      pbk_pkg::F_LBA: v = b.lba;
      default: v = '0;
    endcase
    return v;
  endfunction

  // bus decode: single-cycle classic answer, ack the cycle after request
  assign req = WB_CYC_I && WB_STB_I && !r.ack;
  assign wr = req && WB_WE_I;
  // bank words follow the globals; the gap between reads zero
  assign in_bank = WB_ADR_I >= BANK_BASE && 9'(WB_ADR_I) < 9'(BANK_BASE) + 9'(BANK_SPAN);
  assign boff = 9'(WB_ADR_I) - 9'(BANK_BASE);
  // view data reaches any bank, even those past the map
  assign via_view = WB_ADR_I == pbk_pkg::OFF_VIEW_DATA;
  assign widx = via_view ? r.bank_view_select : 3'(boff / 9'(BANK_STRIDE));
  assign wfld = via_view ? r.view_field : 4'((boff % 9'(BANK_STRIDE)) >> 2);
  // byte lanes merge into the old value of the field
  assign old_val = field_of(r.bank[widx], wfld);
  assign wval = {WB_SEL_I[1] ? WB_DAT_I[15:8] : old_val[15:8],
                 WB_SEL_I[0] ? WB_DAT_I[7:0] : old_val[7:0]};
  // defaults for the newly written unit and input type
  assign unit_dflt = bank_default(WB_DAT_I[pbk_pkg::C_ANALOG], WB_DAT_I[pbk_pkg::C_TUNIT],
                                  1'b0);

  // accepted range of the field being written
  always_comb begin
    lo_b = pbk_pkg::DEF_ZERO;
    hi_b = pbk_pkg::T_MAX;
    unique case (wfld)
      pbk_pkg::F_P, pbk_pkg::F_CP: lo_b = pbk_pkg::P_MIN;
      pbk_pkg::F_DB: begin
        lo_b = r.ctrl[pbk_pkg::C_ANALOG] ? pbk_pkg::DB_MIN_A : pbk_pkg::DB_MIN_T;
        hi_b = r.ctrl[pbk_pkg::C_ANALOG] ? pbk_pkg::DB_MAX_A : pbk_pkg::DB_MAX_T;
      end
      pbk_pkg::F_MR: hi_b = pbk_pkg::MR_MAX;
      pbk_pkg::F_OLH: begin
        lo_b = r.ctrl[pbk_pkg::C_HEATCOOL] ? pbk_pkg::DEF_ZERO
             : r.bank[widx].oll + pbk_pkg::ONE_STEP;
        hi_b = pbk_pkg::OL_MAX;
      end
      pbk_pkg::F_OLL: begin
        lo_b = r.ctrl[pbk_pkg::C_HEATCOOL] ? pbk_pkg::OL_MIN_HC : pbk_pkg::OL_MIN_STD;
        hi_b = r.ctrl[pbk_pkg::C_HEATCOOL] ? pbk_pkg::DEF_ZERO
             : r.bank[widx].olh - pbk_pkg::ONE_STEP;
      end
      pbk_pkg::F_ASEL: lo_b = pbk_pkg::DB_MIN_T;
      default: begin
        lo_b = pbk_pkg::DEF_ZERO;
        hi_b = pbk_pkg::T_MAX;
      end
    endcase
  end

  // one fold for every field, only the bounds differ
  pbk_field_clamp u_clamp (
    .val(wval),
    .lo(lo_b),
    .hi(hi_b),
    .res(clamped)
  );

  // only the active bank reaches the output stage
  assign act = r.bank[r.active];
  assign lim.upper = act.olh;
  assign lim.lower = act.oll;
  assign lim.dead_band = act.db;
  assign lim.bias = act.mr;
  // bias only while integral action is off
  assign lim.bias_en = act.i == pbk_pkg::DEF_ZERO;

  // edits to other banks stay latent until made active
  pbk_mv_stage u_mv (
    .mv_in(r.mv_in),
    .heat_cool(r.ctrl[pbk_pkg::C_HEATCOOL]),
    .floating(r.ctrl[pbk_pkg::C_FLOAT]),
    .derivative_add(act.d != pbk_pkg::DEF_ZERO),
    .derivative(DERIV_TERM),
    .lim(lim),
    .mv_out(mv_c),
    .hit_hi(hit_hi),
    .hit_lo(hit_lo)
  );

  // next state: bus writes, tuning, unit change, output register
  always_comb begin
    next_r = r;
    next_r.ack = req;
    next_r.mv_q = mv_c;
    next_r.hi_q = hit_hi;
    next_r.lo_q = hit_lo;
    // pulse bits of control read back as zero
    next_r.ctrl[pbk_pkg::C_TUNE] = 1'b0;
    next_r.ctrl[pbk_pkg::C_STEP_UP] = 1'b0;
    next_r.ctrl[pbk_pkg::C_STEP_DN] = 1'b0;
    if (wr && WB_SEL_I[0]) begin
      unique case (WB_ADR_I)
        pbk_pkg::OFF_CTRL: begin
          next_r.ctrl = WB_DAT_I[7:0];
          // pulse bits act once and are never stored
          next_r.ctrl[pbk_pkg::C_TUNE] = 1'b0;
          next_r.ctrl[pbk_pkg::C_STEP_UP] = 1'b0;
          next_r.ctrl[pbk_pkg::C_STEP_DN] = 1'b0;
          if (WB_DAT_I[pbk_pkg::C_TUNIT] != r.ctrl[pbk_pkg::C_TUNIT]) begin
            for (int k = 0; k < pbk_pkg::NBANK; k++) begin
              next_r.bank[k].p = unit_dflt.p;
              next_r.bank[k].i = unit_dflt.i;
              next_r.bank[k].d = unit_dflt.d;
              next_r.bank[k].cp = next_r.bank[k].p;
              next_r.bank[k].ci = next_r.bank[k].i;
              next_r.bank[k].cd = next_r.bank[k].d;
            end
          end
          if (WB_DAT_I[pbk_pkg::C_MON_ON]) begin
            next_r.monitor = 1'b1;
          end
          // stepping wraps within 0..7 and drops live monitoring
          if (WB_DAT_I[pbk_pkg::C_STEP_UP]) begin
            next_r.bank_view_select = r.bank_view_select + 3'h1;
            next_r.monitor = 1'b0;
          end else if (WB_DAT_I[pbk_pkg::C_STEP_DN]) begin
            next_r.bank_view_select = r.bank_view_select - 3'h1;
            next_r.monitor = 1'b0;
          end
          // tuning result lands in the viewed bank, cooling copied for heat/cool
          if (WB_DAT_I[pbk_pkg::C_TUNE]) begin
            next_r.bank[r.bank_view_select].p = r.tune_p;
            next_r.bank[r.bank_view_select].i = r.tune_i;
            next_r.bank[r.bank_view_select].d = r.tune_d;
            if (r.ctrl[pbk_pkg::C_HEATCOOL]) begin
              next_r.bank[r.bank_view_select].cp = r.tune_p;
              next_r.bank[r.bank_view_select].ci = r.tune_i;
              next_r.bank[r.bank_view_select].cd = r.tune_d;
            end
            next_r.tune_done = 1'b1;
          end
        end
        pbk_pkg::OFF_SELECT: next_r.bank_view_select = WB_DAT_I[2:0];
        // a newly active bank is also the viewed one
        pbk_pkg::OFF_ACTIVE: begin
          next_r.active = WB_DAT_I[2:0];
          next_r.bank_view_select = WB_DAT_I[2:0];
        end
        // computed value and tuning results come from software
        pbk_pkg::OFF_MV_IN: next_r.mv_in = WB_DAT_I[15:0];
        pbk_pkg::OFF_TUNE_P: next_r.tune_p = WB_DAT_I[15:0];
        pbk_pkg::OFF_TUNE_I: next_r.tune_i = WB_DAT_I[15:0];
        pbk_pkg::OFF_TUNE_D: next_r.tune_d = WB_DAT_I[15:0];
        // tune done clears on a written one
        pbk_pkg::OFF_STATUS: begin
          if (WB_DAT_I[pbk_pkg::S_TUNE_DONE]) begin
            next_r.tune_done = 1'b0;
          end
        end
        // field index used by the view data word
        pbk_pkg::OFF_VIEW_FIELD: next_r.view_field = WB_DAT_I[3:0];
        default: begin
          // per-bank field write, folded into its range
          if ((in_bank || via_view) && wfld < pbk_pkg::NFIELD) begin
            unique case (wfld)
              pbk_pkg::F_P: next_r.bank[widx].p = clamped;
              pbk_pkg::F_I: next_r.bank[widx].i = clamped;
              pbk_pkg::F_D: next_r.bank[widx].d = clamped;
              pbk_pkg::F_CP: next_r.bank[widx].cp = clamped;
              pbk_pkg::F_CI: next_r.bank[widx].ci = clamped;
              pbk_pkg::F_CD: next_r.bank[widx].cd = clamped;
              pbk_pkg::F_DB: next_r.bank[widx].db = clamped;
              pbk_pkg::F_MR: next_r.bank[widx].mr = clamped;
              pbk_pkg::F_OLH: next_r.bank[widx].olh = clamped;
              pbk_pkg::F_OLL: next_r.bank[widx].oll = clamped;
              pbk_pkg::F_ASEL: next_r.bank[widx].asel = clamped;
              default: next_r.bank[widx].lba = clamped;
            endcase
          end
        end
      endcase
    end
    // read mux, captured with the ack; unmapped words read zero
    next_r.rdata = '0;
    if (req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        pbk_pkg::OFF_CTRL: next_r.rdata = {24'h000000, r.ctrl};
        pbk_pkg::OFF_SELECT: next_r.rdata = {29'h00000000, r.bank_view_select};
        pbk_pkg::OFF_ACTIVE: next_r.rdata = {29'h00000000, r.active};
        pbk_pkg::OFF_MV_IN: next_r.rdata = {16'h0000, r.mv_in};
        pbk_pkg::OFF_MV_OUT: next_r.rdata = {16'h0000, r.mv_q};
        pbk_pkg::OFF_TUNE_P: next_r.rdata = {16'h0000, r.tune_p};
        pbk_pkg::OFF_TUNE_I: next_r.rdata = {16'h0000, r.tune_i};
        pbk_pkg::OFF_TUNE_D: next_r.rdata = {16'h0000, r.tune_d};
        pbk_pkg::OFF_STATUS: next_r.rdata = {28'h0000000, r.lo_q, r.hi_q, r.tune_done,
                                             r.monitor};
        pbk_pkg::OFF_VIEW_DATA: next_r.rdata = {16'h0000,
                                  field_of(r.bank[r.bank_view_select], r.view_field)};
        pbk_pkg::OFF_VIEW_FIELD: next_r.rdata = {28'h0000000, r.view_field};
        default: begin
          if (in_bank) begin
            next_r.rdata = {16'h0000, field_of(r.bank[widx], wfld)};
          end
        end
      endcase
    end
  end

  // single state register with synchronous active-low reset
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      r <= '0;
      r.monitor <= 1'b1;
      // temperature input, whole-second defaults
      for (int k = 0; k < pbk_pkg::NBANK; k++) begin
        r.bank[k] <= bank_default(1'b0, 1'b0, 1'b0);
      end
    end else begin
      r <= next_r;
    end
  end

  // ports straight from flops, no bus-to-bus path
  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.rdata;
  assign MANIPULATED_VARIABLE = r.mv_q;
endmodule

// ===== bench/pbk_bank_asserts.sv
// checker: bus handshake, read data and reset behaviour at the bank's ports
`timescale 1ns/1ps
module pbk_bank_asserts (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // output stage
  input wire logic [15:0] MANIPULATED_VARIABLE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // a taken request is answered on the very next edge
  property p_ack_next;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  // ack is a single-cycle pulse
  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  // no ack without a request behind it
  property p_ack_cause;
    $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // idle bus gives no answer
  property p_idle_quiet;
    !WB_CYC_I |=> !WB_ACK_O;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("ack on idle bus");
  // read data only shows during a read ack
  property p_dat_quiet;
    !WB_ACK_O |-> WB_DAT_O == 32'h00000000;
  endproperty
  a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
  property p_write_dat;
    WB_ACK_O && WB_WE_I |-> WB_DAT_O == 32'h00000000;
  endproperty
  a_write_dat: assert property (p_write_dat) else $error("read data on write ack");
  // unmapped hole between the globals and the first bank reads zero
  property p_hole_zero;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h30
      |=> WB_ACK_O && WB_DAT_O == 32'h00000000;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  // reset clears the answer and the output, so it must not be disabled by itself
  property p_reset_clear;
    disable iff (1'b0) !RSTN |=> !WB_ACK_O && MANIPULATED_VARIABLE == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");
endmodule
bind pbk_bank pbk_bank_asserts pbk_bank_asserts_i (.REF_CLK(REF_CLK), .RSTN(RSTN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .MANIPULATED_VARIABLE(MANIPULATED_VARIABLE));

// ===== bench/pbk_bank_bench.sv
// bench: register access, bank selection and output stage of the parameter bank
`timescale 1ns/1ps
module pbk_bank_bench;
  logic clk;
  logic rstn;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [31:0] dat_w;
  logic [3:0] sel;
  logic [31:0] dat_r;
  logic ack;
  logic [15:0] deriv;
  logic [15:0] mv;
  logic [31:0] rd;
  int n_errors;
  int num_checks;
  // reset contents of a bank, P through break time
  logic [15:0] dflt [12] = '{16'h0050, 16'h00E9, 16'h0028, 16'h0050, 16'h00E9, 16'h0028,
    16'h0000, 16'h01F4, 16'h03E8, 16'h0000, 16'h0528, 16'h0000};
  pbk_bank pbk_bank_i (.REF_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat_w), .WB_SEL_I(sel), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .DERIV_TERM(deriv), .MANIPULATED_VARIABLE(mv));
  // verdict, reached from the end of the sequence and from any timeout
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; ack and read data are taken at one rising edge, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("[FAIL] bus ack expected 1 seen %b", ack);
      close_out();
    end else begin
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, {16'h0000, d}, 4'h3);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    wb(1'b0, a, 32'h00000000, 4'h3);
    chk(what, {16'h0000, exp}, {16'h0000, rd[15:0]});
  endtask
  // output is registered every cycle, so a few cycles settle it
  task automatic mvchk(input string what, input logic [15:0] v, input logic [15:0] exp);
    wr(pbk_pkg::OFF_MV_IN, v);
    repeat (3) @(negedge clk);
    chk(what, {16'h0000, exp}, {16'h0000, mv});
  endtask
  function automatic logic [7:0] fa(input logic [2:0] n, input logic [3:0] f);
    return 8'h40 + 8'(n) * 8'h30 + 8'(f) * 8'h04;
  endfunction
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h00000000;
    sel = 4'h0;
    deriv = 16'h0000;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // defaults and view selector
    for (int f = 0; f < 12; f++) begin
      rdchk("bank0 field", fa(3'h0, 4'(f)), dflt[f]);
    end
    rdchk("bank2 upper", fa(3'h2, pbk_pkg::F_OLH), 16'h03E8);
    rdchk("view select", pbk_pkg::OFF_SELECT, 16'h0000);
    wr(pbk_pkg::OFF_ACTIVE, 16'h0002);
    rdchk("view follows active", pbk_pkg::OFF_SELECT, 16'h0002);
    rdchk("monitor on", pbk_pkg::OFF_STATUS, 16'h0001);
    wr(pbk_pkg::OFF_CTRL, 16'h0020);
    rdchk("step up", pbk_pkg::OFF_SELECT, 16'h0003);
    wb(1'b0, pbk_pkg::OFF_STATUS, 32'h00000000, 4'h3);
    chk("monitor cancel", 32'h0, {31'h0, rd[pbk_pkg::S_MON]});
    wr(pbk_pkg::OFF_CTRL, 16'h0040);
    rdchk("step down", pbk_pkg::OFF_SELECT, 16'h0002);
    rdchk("pulses read 0", pbk_pkg::OFF_CTRL, 16'h0000);
    wr(pbk_pkg::OFF_ACTIVE, 16'h0000);
    // edit bank 1 through the view path while bank 0 is active
    wr(pbk_pkg::OFF_SELECT, 16'h0001);
    wr(pbk_pkg::OFF_VIEW_FIELD, {12'h000, pbk_pkg::F_OLH});
    wr(pbk_pkg::OFF_VIEW_DATA, 16'h012C);
    rdchk("view write", fa(3'h1, pbk_pkg::F_OLH), 16'h012C);
    rdchk("view read", pbk_pkg::OFF_VIEW_DATA, 16'h012C);
    mvchk("clamp high", 16'h07D0, 16'h03E8);
    rdchk("clamp flag high", pbk_pkg::OFF_STATUS, 16'h0004);
    mvchk("clamp low", 16'hFED4, 16'h0000);
    rdchk("clamp flag low", pbk_pkg::OFF_STATUS, 16'h0008);
    mvchk("inactive edit", 16'h01F4, 16'h01F4);
    wr(pbk_pkg::OFF_ACTIVE, 16'h0001);
    mvchk("active edit", 16'h01F4, 16'h012C);
    rdchk("mv out", pbk_pkg::OFF_MV_OUT, 16'h012C);
    wr(pbk_pkg::OFF_ACTIVE, 16'h0000);
    // derivative, bias and floating
    deriv <= 16'h001E;
    mvchk("derivative add", 16'h0064, 16'h0082);
    wr(fa(3'h0, pbk_pkg::F_D), 16'h0000);
    mvchk("derivative off", 16'h0064, 16'h0064);
    wr(fa(3'h0, pbk_pkg::F_I), 16'h0000);
    mvchk("bias add", 16'h0064, 16'h0258);
    wr(fa(3'h0, pbk_pkg::F_I), 16'h00E9);
    wr(pbk_pkg::OFF_CTRL, 16'h0008);
    mvchk("floating", 16'h07D0, 16'h07D0);
    // range folding, refused lane, unmapped place
    wr(fa(3'h0, pbk_pkg::F_P), 16'h0000);
    rdchk("band min", fa(3'h0, pbk_pkg::F_P), 16'h0001);
    wr(fa(3'h0, pbk_pkg::F_P), 16'h4E20);
    rdchk("band max", fa(3'h0, pbk_pkg::F_P), 16'h270F);
    wb(1'b1, fa(3'h0, pbk_pkg::F_P), 32'h00000055, 4'h0);
    rdchk("lane refused", fa(3'h0, pbk_pkg::F_P), 16'h270F);
    wr(8'h30, 16'h1234);
    rdchk("unmapped", 8'h30, 16'h0000);
    // heating/cooling: negative cooling, dead band zone and overlap
    wr(pbk_pkg::OFF_CTRL, 16'h0004);
    wr(fa(3'h0, pbk_pkg::F_OLL), 16'hFDA8);
    rdchk("lower limit", fa(3'h0, pbk_pkg::F_OLL), 16'hFDA8);
    mvchk("cooling limit", 16'hFCE0, 16'hFDA8);
    wr(fa(3'h0, pbk_pkg::F_DB), 16'h0064);
    mvchk("zone heat", 16'h0028, 16'h0000);
    mvchk("zone cool", 16'hFFD8, 16'h0000);
    mvchk("outside zone", 16'h003C, 16'h003C);
    wr(fa(3'h0, pbk_pkg::F_DB), 16'hFF9C);
    mvchk("overlap", 16'h0028, 16'h0028);
    // tuning into the viewed bank, cooling copied in heat/cool
    wr(pbk_pkg::OFF_TUNE_P, 16'h006F);
    wr(pbk_pkg::OFF_TUNE_I, 16'h00DE);
    wr(pbk_pkg::OFF_TUNE_D, 16'h014D);
    wr(pbk_pkg::OFF_SELECT, 16'h0002);
    wr(pbk_pkg::OFF_CTRL, 16'h0014);
    rdchk("tuned band", fa(3'h2, pbk_pkg::F_P), 16'h006F);
    rdchk("tuned deriv", fa(3'h2, pbk_pkg::F_D), 16'h014D);
    rdchk("tuned cool band", fa(3'h2, pbk_pkg::F_CP), 16'h006F);
    wb(1'b0, pbk_pkg::OFF_STATUS, 32'h00000000, 4'h3);
    chk("tune done", 32'h1, {31'h0, rd[pbk_pkg::S_TUNE_DONE]});
    // time unit change restores constants in every bank
    wr(fa(3'h0, pbk_pkg::F_P), 16'h007B);
    wr(pbk_pkg::OFF_CTRL, 16'h0005);
    rdchk("unit band", fa(3'h0, pbk_pkg::F_P), 16'h0050);
    rdchk("unit integral", fa(3'h0, pbk_pkg::F_I), 16'h091A);
    rdchk("unit cool deriv", fa(3'h2, pbk_pkg::F_CD), 16'h0190);
    wr(pbk_pkg::OFF_CTRL, 16'h0006);
    rdchk("analog band", fa(3'h1, pbk_pkg::F_P), 16'h0064);
    close_out();
  end
endmodule
